// file: common/ledi_pkg.sv
// Constants and types shared by the status indicator block
package ledi_pkg;

  // Clock and pacing of toggle and flash phases
  localparam int unsigned CLK_PERIOD_NS  = 10;        // 100 MHz device clock
  localparam int unsigned BLINK_HALF_MS  = 50;        // Length of one visible on or off phase
  localparam int unsigned BLINK_HALF_CYC =
    (BLINK_HALF_MS * 1000000) / CLK_PERIOD_NS;        // Longest time, rounded down
  localparam int unsigned DIV_W          = 32;        // Width of the free-running divider

  // Standard indicator pin bank layout
  localparam int unsigned STD_PINS = 7;               // Number of dual-purpose pins
  localparam int unsigned IDX_SPD0 = 0;               // Speed pair bit 0 (100 Mbps)
  localparam int unsigned IDX_SPD1 = 1;               // Speed pair bit 1 (10 Mbps)
  localparam int unsigned IDX_LNK  = 2;               // Link indicator
  localparam int unsigned IDX_DPX  = 3;               // Duplex indicator
  localparam int unsigned IDX_TX   = 4;               // Transmit activity
  localparam int unsigned IDX_RX   = 5;               // Receive activity
  localparam int unsigned IDX_COL  = 6;               // Collision indicator

  // Activity channel layout
  localparam int unsigned ACT_CH  = 3;                // Transmit, receive, collision
  localparam int unsigned ACH_TX  = 0;
  localparam int unsigned ACH_RX  = 1;
  localparam int unsigned ACH_COL = 2;

  // Advanced indicator bank layout, in resolved mode order
  localparam int unsigned ADV_PINS = 4;
  localparam int unsigned ADV_10H  = 0;
  localparam int unsigned ADV_10F  = 1;
  localparam int unsigned ADV_100H = 2;
  localparam int unsigned ADV_100F = 3;

  // Reset values
  localparam logic       RST_BIT   = 1'h0;            // Any single control bit
  localparam logic [6:0] RST_STD   = 7'h00;           // Standard bank vectors
  localparam logic [3:0] RST_ADV   = 4'h0;            // Advanced bank vector
  localparam logic [2:0] RST_ACT   = 3'h0;            // Activity channel vectors
  localparam logic [31:0] RST_DIV  = 32'h0000_0000;   // Divider count

  // Resolved link mode
  typedef enum logic [2:0] {
    MODE_NONE,
    MODE_10H,
    MODE_10F,
    MODE_100H,
    MODE_100F
  } ledi_mode_e;

endpackage : ledi_pkg

// file: verification/ledi_board.sv
// Board strap resistors around the dual-purpose pins
`timescale 1ns/100ps
module ledi_board
(
  // Strap level and device drive
  input  wire logic [6:0] strap,
  input  wire logic [6:0] drv,
  input  wire logic [6:0] oe,
  // Resolved pin level
  output      logic [6:0] pin
);
  // Undriven pins rest at their strap level, sampled at reset release
  assign pin = (oe & drv) | (~oe & strap);
endmodule : ledi_board

// file: verification/ledi_status_assertions.sv
// Port checker for the status indicator block
`timescale 1ns/100ps
module ledi_chk
#(
  parameter int unsigned BLINK_CYC = 8
)
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Core status
  input wire logic       link_up,
  input wire logic       speed_100,
  input wire logic       full_duplex,
  input wire logic       tx_active,
  input wire logic       rx_active,
  input wire logic       collision,
  // Captured configuration
  input wire logic       adv_sel,
  input wire logic [ledi_pkg::STD_PINS-1:0] std_active_low,
  // Standard pins
  input wire logic [1:0] speed_pair_in,
  input wire logic [1:0] speed_pair_out,
  input wire logic       link_ind_in,
  input wire logic       link_ind_out,
  input wire logic       link_ind_oe,
  input wire logic       duplex_ind_in,
  input wire logic       duplex_ind_out,
  input wire logic       tx_activity_in,
  input wire logic       tx_activity_out,
  input wire logic       rx_activity_in,
  input wire logic       rx_activity_out,
  input wire logic       collision_ind_in,
  input wire logic       collision_ind_out,
  // Advanced outputs
  input wire logic       adv_ten_half_out,
  input wire logic       adv_ten_full_alt,
  input wire logic       adv_hundred_half_out,
  input wire logic       adv_hundred_full_out
);
  import ledi_pkg::*;
  // Three phases, the pin stage and some slack
  localparam int LIM = 3 * BLINK_CYC + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [2:0] mode_prev_reg; // Mode inputs one edge ago
  logic [3:0] lit_reg;       // Advanced output due for them
  int         rxq_reg;       // Edges free of receive, collision or mode change
  int         txq_reg;       // Edges free of transmit, collision or mode change
  int         rxa_reg;       // Edges of unbroken receive
  wire [6:0] pin_in  = {collision_ind_in, rx_activity_in, tx_activity_in,
                        duplex_ind_in, link_ind_in, speed_pair_in};
  wire [6:0] pin_out = {collision_ind_out, rx_activity_out, tx_activity_out,
                        duplex_ind_out, link_ind_out, speed_pair_out};
  wire [3:0] adv_vec = {adv_hundred_full_out, adv_hundred_half_out,
                        adv_ten_full_alt, adv_ten_half_out};
  wire [2:0] mode_now = {link_up, speed_100, full_duplex};
  wire       mode_chg = (mode_now != mode_prev_reg);
  // Saturating counters, cleared in reset so no stale count survives
  always_ff @(posedge clk)
  begin
    mode_prev_reg <= mode_now;
    lit_reg       <= link_up ? (4'h1 << {speed_100, full_duplex}) : 4'h0;
    if (!nrst || rx_active || collision || mode_chg)
      rxq_reg <= 0;
    else if (rxq_reg < LIM)
      rxq_reg <= rxq_reg + 1;
    if (!nrst || tx_active || collision || mode_chg)
      txq_reg <= 0;
    else if (txq_reg < LIM)
      txq_reg <= txq_reg + 1;
    if (!nrst || !rx_active || !link_up || mode_chg)
      rxa_reg <= 0;
    else if (rxa_reg < LIM)
      rxa_reg <= rxa_reg + 1;
  end
  // Long receive burst, then a flip of the receive pin
  sequence s_rx_busy;
    !adv_sel && link_ind_oe && rxa_reg >= LIM;
  endsequence
  sequence s_rx_flip;
    ##[1:LIM] $changed(rx_activity_out);
  endsequence
  AST_POL_CAPTURE: assert property (
    $rose(nrst) |=> std_active_low == $past(pin_in))
    else $error("Polarity not taken from straps");
  AST_POL_HOLD: assert property (
    $past(nrst) && $past(nrst, 2) |-> $stable(std_active_low) && $stable(adv_sel))
    else $error("Configuration moved after capture");
  AST_LINK_DPX: assert property (
    link_ind_oe && !adv_sel |-> {duplex_ind_out, link_ind_out} ==
    ({$past(link_up) && $past(full_duplex), $past(link_up)} ^ std_active_low[3:2]))
    else $error("Link or duplex pin wrong");
  AST_SPEED: assert property (
    link_ind_oe && !adv_sel |-> speed_pair_out == ({$past(link_up) && !$past(speed_100),
    $past(link_up) && $past(speed_100)} ^ std_active_low[1:0]))
    else $error("Speed pair wrong");
  AST_STD_OFF: assert property (
    adv_sel && link_ind_oe |-> pin_out == std_active_low)
    else $error("Standard pin lit in advanced set");
  AST_ADV_DARK: assert property (
    !adv_sel |-> adv_vec == 4'h0)
    else $error("Advanced output lit in standard set");
  AST_ADV_QUIET: assert property (
    adv_sel && rxq_reg >= LIM && (txq_reg >= LIM || lit_reg[ADV_10F] || lit_reg[ADV_100F])
    |-> adv_vec == lit_reg)
    else $error("Advanced output not steady on");
  AST_STD_IDLE: assert property (
    !adv_sel && link_ind_oe && rxq_reg >= LIM && txq_reg >= LIM
    |-> pin_out[6:4] == std_active_low[6:4])
    else $error("Activity pin not back off");
  AST_RX_TOGGLES: assert property (
    s_rx_busy |-> s_rx_flip)
    else $error("Receive pin not toggling");
endmodule : ledi_chk

bind ledi_status ledi_chk #(.BLINK_CYC(BLINK_CYC)) u_ledi_chk (
  .clk(clk), .nrst(nrst), .link_up(link_up), .speed_100(speed_100),
  .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
  .collision(collision), .adv_sel(adv_sel), .std_active_low(std_active_low),
  .speed_pair_in(speed_pair_in), .speed_pair_out(speed_pair_out),
  .link_ind_in(link_ind_in), .link_ind_out(link_ind_out), .link_ind_oe(link_ind_oe),
  .duplex_ind_in(duplex_ind_in), .duplex_ind_out(duplex_ind_out),
  .tx_activity_in(tx_activity_in), .tx_activity_out(tx_activity_out),
  .rx_activity_in(rx_activity_in), .rx_activity_out(rx_activity_out),
  .collision_ind_in(collision_ind_in), .collision_ind_out(collision_ind_out),
  .adv_ten_half_out(adv_ten_half_out), .adv_ten_full_alt(adv_ten_full_alt),
  .adv_hundred_half_out(adv_hundred_half_out),
  .adv_hundred_full_out(adv_hundred_full_out));

// file: verification/tb_top.sv
// Self-checking bench for the status indicator block
`timescale 1ns/100ps
module tb_top;
  import ledi_pkg::*;
  localparam int BC = 8; // Short phase keeps the run brief
  logic        clk, nrst, link_up, speed_100, full_duplex;
  logic        tx_active, rx_active, collision, adv_sel_strap;
  logic [6:0]  strap;
  wire  [6:0]  pin, drv, oe, std_active_low;
  wire         adv_sel;
  wire  [3:0]  adv;
  logic [21:0] ind_q[$], got_ind; // Toggle mask then final levels
  logic [7:0]  pol_q[$], got_pol; // Set select then polarity
  event        ind_ev, pol_ev;
  int          n_mismatch, check_count;
  logic [31:0] lfsr_reg;
  // Mode {link, 100, full} and activity {col, rx, tx}
  logic [5:0]  tbl[13] = '{6'h20, 6'h28, 6'h30, 6'h38, 6'h02, 6'h3a, 6'h39,
                           6'h34, 6'h2b, 6'h3c, 6'h21, 6'h29, 6'h22};
  ledi_status #(.BLINK_CYC(BC)) DUT (
    .clk(clk), .nrst(nrst), .link_up(link_up), .speed_100(speed_100),
    .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active),
    .collision(collision), .adv_sel_strap(adv_sel_strap), .adv_sel(adv_sel),
    .speed_pair_in(pin[1:0]), .speed_pair_out(drv[1:0]), .speed_pair_oe(oe[1:0]),
    .link_ind_in(pin[2]), .link_ind_out(drv[2]), .link_ind_oe(oe[2]),
    .duplex_ind_in(pin[3]), .duplex_ind_out(drv[3]), .duplex_ind_oe(oe[3]),
    .tx_activity_in(pin[4]), .tx_activity_out(drv[4]), .tx_activity_oe(oe[4]),
    .rx_activity_in(pin[5]), .rx_activity_out(drv[5]), .rx_activity_oe(oe[5]),
    .collision_ind_in(pin[6]), .collision_ind_out(drv[6]), .collision_ind_oe(oe[6]),
    .std_active_low(std_active_low), .adv_ten_half_out(adv[0]),
    .adv_ten_full_alt(adv[1]), .adv_hundred_half_out(adv[2]),
    .adv_hundred_full_out(adv[3]));
  ledi_board BRD (.strap(strap), .drv(drv), .oe(oe), .pin(pin));
  // 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic cmp_pol(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: polarity exp %h got %h", $time, e, g);
    end
  endtask : cmp_pol
  task automatic cmp_ind(input logic [21:0] e, input logic [21:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t: indicators exp %h got %h", $time, e, g);
    end
  endtask : cmp_ind
  // Reset with random straps; polarity due is the strap level
  task automatic do_reset(input logic a);
    lfsr_reg = lfsr_next(lfsr_reg);
    @(posedge clk);
    nrst          <= 1'h0;
    strap         <= lfsr_reg[6:0];
    adv_sel_strap <= a;
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    pol_q.push_back({a, strap});
    got_pol = {adv_sel, std_active_low};
    -> pol_ev;
  endtask : do_reset
  // One mode with a burst of activity; note toggles and final levels
  task automatic run(input logic [2:0] md, input logic [2:0] act);
    logic [10:0] prev, tg;
    logic [6:0]  ston;
    logic [3:0]  adon;
    logic [2:0]  sttg;
    logic        hc, fl;
    hc   = act[2] & !md[0]; // Collision counts in half duplex only
    ston = {3'h0, md[2] & md[0], md[2], md[2] & !md[1], md[2] & md[1]};
    sttg = {hc, act[1] | hc, act[0] | hc} & {3{md[2]}};
    adon = md[2] ? (4'h1 << md[1:0]) : 4'h0;
    fl   = act[1] | hc | (!md[0] & act[0]); // Transmit flashes half duplex only
    tg   = 11'h000;
    @(posedge clk);
    {link_up, speed_100, full_duplex} <= md;
    repeat (3) @(posedge clk);
    {collision, rx_active, tx_active} <= act;
    @(negedge clk);
    prev = {adv, pin};
    for (int c = 0; c < 9 * BC; c++)
    begin
      @(posedge clk);
      if (c == 4 * BC)
        {collision, rx_active, tx_active} <= 3'h0;
      @(negedge clk);
      tg   = tg | (prev ^ {adv, pin});
      prev = {adv, pin};
    end
    if (adv_sel_strap)
      ind_q.push_back({adon & {4{fl}}, 7'h00, adon, strap});
    else
      ind_q.push_back({4'h0, sttg, 4'h0, 4'h0, ston ^ strap});
    got_ind = {tg, prev};
    -> ind_ev;
  endtask : run
  // Monitors take the oldest note as each result appears
  initial
  forever
  begin
    @(pol_ev);
    cmp_pol(pol_q.pop_front(), got_pol);
  end
  initial
  forever
  begin
    @(ind_ev);
    cmp_ind(ind_q.pop_front(), got_ind);
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Watchdog, about five times the expected run
  initial
  begin
    #100000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // Standard set, then advanced set after a mid-run reset
  initial
  begin
    lfsr_reg = 32'h0001_80a1;
    {nrst, link_up, speed_100, full_duplex} <= 4'h0;
    {tx_active, rx_active, collision, adv_sel_strap} <= 4'h0;
    strap <= 7'h7f;
    for (int s = 0; s < 2; s++)
    begin
      do_reset(s[0]);
      foreach (tbl[i])
        run(tbl[i][5:3], tbl[i][2:0]);
      $display("test with advanced select %0d done", s);
    end
    // Let the monitors take the last notes before the verdict
    @(posedge clk);
    tally_and_finish();
  end
endmodule : tb_top

// file: verilog/ledi_pin.sv
// One dual-purpose strap and indicator pin with latched polarity
`timescale 1ns/100ps
module ledi_pin
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin side
  input  wire logic pin_in,
  output      logic pin_out,
  output      logic pin_oe,
  // Core side
  input  wire logic on_req,
  output      logic active_low
);
  import ledi_pkg::*;

  logic done_reg;        // Strap level has been captured
  logic low_reg;         // Captured polarity, 1 = active low
  logic out_reg;         // Driven pin level
  logic oe_reg;          // Driver enable
  logic out_next;        // Level for the current request

  // Polarity turns the on request into a pin level
  assign out_next   = on_req ^ low_reg;
  assign pin_out    = out_reg;
  assign pin_oe     = oe_reg;
  assign active_low = low_reg;

  // Strap capture at the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      done_reg <= RST_BIT;
      low_reg  <= RST_BIT;
    end
    else if (!done_reg)
    begin
      // Driver still off, so the pin shows its resistor level
      done_reg <= 1'h1;
      low_reg  <= pin_in;
    end
  end

  // Driver comes on one edge after capture, never during reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_reg <= RST_BIT;
      oe_reg  <= RST_BIT;
    end
    else
    begin
      oe_reg  <= done_reg;
      out_reg <= done_reg ? out_next : RST_BIT;
    end
  end

endmodule : ledi_pin

// file: verilog/ledi_status.sv
// Status indicator driver with strap-configured pins
//
// Overview of operation
// - Pins capture strap level at reset release
// - Strap low makes the driver active high
// - Strap high makes the driver active low
// - Standard set shows link, duplex, speed pair
// - Activity outputs toggle, half-duplex collision toggles three, end off
// - Active-low standard set: on low, off high
// - Advanced set lights one output per mode
// - Half-duplex lit output flashes on any activity
// - Full-duplex lit output flashes on receive only
// - Advanced outputs are high when on
`timescale 1ns/100ps
module ledi_status
#(
  // Half period of toggle and flash, shortened in simulation
  parameter int unsigned BLINK_CYC = ledi_pkg::BLINK_HALF_CYC
)
(
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // Link status from the transceiver core
  input  wire logic                           link_up,
  input  wire logic                           speed_100,
  input  wire logic                           full_duplex,
  input  wire logic                           tx_active,
  input  wire logic                           rx_active,
  input  wire logic                           collision,
  // Indicator set selection strap
  input  wire logic                           adv_sel_strap,
  output      logic                           adv_sel,
  // Speed pair pins
  input  wire logic [1:0]                     speed_pair_in,
  output      logic [1:0]                     speed_pair_out,
  output      logic [1:0]                     speed_pair_oe,
  // Link pin
  input  wire logic                           link_ind_in,
  output      logic                           link_ind_out,
  output      logic                           link_ind_oe,
  // Duplex pin
  input  wire logic                           duplex_ind_in,
  output      logic                           duplex_ind_out,
  output      logic                           duplex_ind_oe,
  // Transmit activity pin
  input  wire logic                           tx_activity_in,
  output      logic                           tx_activity_out,
  output      logic                           tx_activity_oe,
  // Receive activity pin
  input  wire logic                           rx_activity_in,
  output      logic                           rx_activity_out,
  output      logic                           rx_activity_oe,
  // Collision pin
  input  wire logic                           collision_ind_in,
  output      logic                           collision_ind_out,
  output      logic                           collision_ind_oe,
  // Captured polarity of each standard pin, 1 = active low
  output      logic [ledi_pkg::STD_PINS-1:0]  std_active_low,
  // Advanced set outputs, always active high
  output      logic                           adv_ten_half_out,
  output      logic                           adv_ten_full_alt,
  output      logic                           adv_hundred_half_out,
  output      logic                           adv_hundred_full_out
);
  import ledi_pkg::*;

  // Structure in brief:
  //  - a strap and driver cell per standard pin keeps its own polarity
  //  - one divider sets the on and off phases shared by all outputs
  //  - activity is stretched to whole phases before it reaches a pin
  //  - the advanced bank is registered here, one edge after its inputs
  //  - link loss turns every standard output off at once
  // Steady indicators follow the status inputs by one edge. A toggling
  // output may lag the start of activity by up to two phases, since
  // the divider is never restarted for a new burst; that keeps all
  // blinking pins in step at the cost of a short delay.
  // Set selection and pin polarity only change through a reset.

  // Configuration capture
  logic                 cfg_done_reg;     // Selection strap captured
  logic                 adv_reg;          // 1 = advanced set in use

  // Free-running divider
  logic [DIV_W-1:0]     div_reg;          // Cycle count in this phase
  logic [DIV_W-1:0]     div_next;         // Next count
  logic                 tick;             // Phase boundary, one cycle
  logic                 phase_reg;        // Alternates each phase

  // Activity tracking per channel
  logic [ACT_CH-1:0]    act_raw;          // Activity seen this cycle
  logic [ACT_CH-1:0]    act_seen_reg;     // Activity since last tick
  logic [ACT_CH-1:0]    act_live_reg;     // Activity in last full phase
  logic [ACT_CH-1:0]    act_show;         // Channel shows its on phase
  logic                 col_half;         // Collision counted in half duplex

  // Resolved mode
  ledi_mode_e           mode;             // Current link mode
  logic                 adv_flash;        // Activity that flashes the lit output
  logic                 adv_dark;         // Lit output in its dark phase

  // Standard bank
  logic [STD_PINS-1:0]  std_on;           // Logical on state per pin
  logic [STD_PINS-1:0]  std_req;          // Request after set selection
  logic [STD_PINS-1:0]  pin_in_vec;       // Pin levels in bank order
  logic [STD_PINS-1:0]  pin_out_vec;      // Pin drive in bank order
  logic [STD_PINS-1:0]  pin_oe_vec;       // Pin enables in bank order

  // Advanced bank
  logic [ADV_PINS-1:0]  adv_lit;          // Output chosen by the mode
  logic [ADV_PINS-1:0]  adv_next;         // Output levels for next edge
  logic [ADV_PINS-1:0]  adv_out_reg;      // Registered output levels

  // Divider bound, cast once to the counter width
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BLINK_CYC - 1);

  // Set selection strap is caught at the first edge after reset
  // Later strap changes are ignored until the next reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cfg_done_reg <= RST_BIT;
      adv_reg      <= RST_BIT;
    end
    else if (!cfg_done_reg)
    begin
      cfg_done_reg <= 1'h1;
      adv_reg      <= adv_sel_strap;
    end
  end

  // Captured select is reported so a board check can confirm it
  assign adv_sel = adv_reg;

  // Divider wraps every phase so each on or off period is visible;
  // it counts 0 to BLINK_CYC-1, so one phase is BLINK_CYC edges
  assign tick     = (div_reg == DIV_LAST);
  assign div_next = tick ? RST_DIV : DIV_W'(div_reg + 1'h1);

  // Divider and phase flip-flop
  // Phase high is the visible on half of every toggle and flash
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      div_reg   <= RST_DIV;
      phase_reg <= RST_BIT;
    end
    else
    begin
      div_reg   <= div_next;
      phase_reg <= tick ? ~phase_reg : phase_reg;
    end
  end

  // Collisions only count in half duplex and hit all three channels
  // A collision report in full duplex has no meaning and is dropped
  assign col_half         = collision & ~full_duplex & link_up;
  assign act_raw[ACH_TX]  = (tx_active & link_up) | col_half;
  assign act_raw[ACH_RX]  = (rx_active & link_up) | col_half;
  assign act_raw[ACH_COL] = col_half;

  // Short bursts are stretched over a full phase, so a single frame
  // is still seen; activity arriving on the tick is kept, not lost
  // The live vector only moves on a tick, so no pin ever shows a
  // phase shorter than the divider allows, even for a one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      act_seen_reg <= RST_ACT;
      act_live_reg <= RST_ACT;
    end
    else if (tick)
    begin
      act_live_reg <= act_seen_reg | act_raw;
      act_seen_reg <= act_raw;
    end
    else
    begin
      act_seen_reg <= act_seen_reg | act_raw;
    end
  end

  // On phase only while live; once activity stops the output is off
  assign act_show = act_live_reg & {ACT_CH{phase_reg}};

  // Resolve the link mode from speed and duplex
  // Decoded once for the advanced bank; the standard bank decodes link_up, speed_100 and full_duplex itself
  always_comb
  begin
    if (!link_up)
      mode = MODE_NONE;
    else if (speed_100)
      mode = full_duplex ? MODE_100F : MODE_100H;
    else
      mode = full_duplex ? MODE_10F : MODE_10H;
  end

  // Standard set: steady indicators follow link, speed and duplex;
  // speed pair bit 0 is the 100 Mbps lamp and bit 1 the 10 Mbps lamp
  assign std_on[IDX_SPD0] = link_up & speed_100;
  assign std_on[IDX_SPD1] = link_up & ~speed_100;
  assign std_on[IDX_LNK]  = link_up;
  assign std_on[IDX_DPX]  = link_up & full_duplex;
  // Activity pins are also gated by link, so a phase still stretched
  // when the link drops cannot leave a pin blinking with no link
  assign std_on[IDX_TX]   = act_show[ACH_TX] & link_up;
  assign std_on[IDX_RX]   = act_show[ACH_RX] & link_up;
  assign std_on[IDX_COL]  = act_show[ACH_COL] & link_up;

  // In the advanced set the standard pins rest in their off level
  // A low request parks each pin at its own off level, whichever
  // polarity its strap chose
  assign std_req = adv_reg ? RST_STD : std_on;

  // Pin bank in the order the bank indices give
  // Pin levels only matter to the cells before their drivers come on
  assign pin_in_vec[IDX_SPD0] = speed_pair_in[0];
  assign pin_in_vec[IDX_SPD1] = speed_pair_in[1];
  assign pin_in_vec[IDX_LNK]  = link_ind_in;
  assign pin_in_vec[IDX_DPX]  = duplex_ind_in;
  assign pin_in_vec[IDX_TX]   = tx_activity_in;
  assign pin_in_vec[IDX_RX]   = rx_activity_in;
  assign pin_in_vec[IDX_COL]  = collision_ind_in;

  // One strap and driver cell per standard pin; an active-low pin
  // shows on as a low level and off as a high level
  // The cell register adds the one-edge latency of each standard pin
  genvar gi;
  generate
    for (gi = 0; gi < STD_PINS; gi = gi + 1)
    begin : g_pin
      ledi_pin u_pin
      (
        .clk        (clk),
        .nrst       (nrst),
        .pin_in     (pin_in_vec[gi]),
        .pin_out    (pin_out_vec[gi]),
        .pin_oe     (pin_oe_vec[gi]),
        .on_req     (std_req[gi]),
        .active_low (std_active_low[gi])
      );
    end
  endgenerate

  // Bank back to named pins
  // The speed pair is packed back as {10 Mbps, 100 Mbps}
  assign speed_pair_out    = {pin_out_vec[IDX_SPD1], pin_out_vec[IDX_SPD0]};
  assign speed_pair_oe     = {pin_oe_vec[IDX_SPD1], pin_oe_vec[IDX_SPD0]};
  assign link_ind_out      = pin_out_vec[IDX_LNK];
  assign link_ind_oe       = pin_oe_vec[IDX_LNK];
  assign duplex_ind_out    = pin_out_vec[IDX_DPX];
  assign duplex_ind_oe     = pin_oe_vec[IDX_DPX];
  assign tx_activity_out   = pin_out_vec[IDX_TX];
  assign tx_activity_oe    = pin_oe_vec[IDX_TX];
  assign rx_activity_out   = pin_out_vec[IDX_RX];
  assign rx_activity_oe    = pin_oe_vec[IDX_RX];
  assign collision_ind_out = pin_out_vec[IDX_COL];
  assign collision_ind_oe  = pin_oe_vec[IDX_COL];

  // Advanced set: exactly one output per resolved mode
  // No link resolves to no output, so all four rest off
  always_comb
  begin
    adv_lit = RST_ADV;
    case (mode)
      MODE_10H:  adv_lit[ADV_10H]  = 1'h1;
      MODE_10F:  adv_lit[ADV_10F]  = 1'h1;
      MODE_100H: adv_lit[ADV_100H] = 1'h1;
      MODE_100F: adv_lit[ADV_100F] = 1'h1;
      MODE_NONE: adv_lit = RST_ADV;
      default:   adv_lit = RST_ADV;
    endcase
  end

  // Half duplex flashes on either direction, full duplex on receive
  // only, so transmit alone leaves a full-duplex output steady
  assign adv_flash = full_duplex ? act_live_reg[ACH_RX]
                                 : (act_live_reg[ACH_RX] | act_live_reg[ACH_TX]);
  // Dark only while flashing and in the off phase; steady otherwise
  assign adv_dark  = adv_flash & ~phase_reg;

  // Outputs are off unless the advanced set is selected
  assign adv_next = (adv_reg & ~adv_dark) ? adv_lit : RST_ADV;

  // Advanced outputs registered; high means on, low means off
  // The register keeps decode glitches off the board lamps
  always_ff @(posedge clk)
  begin
    if (!nrst)
      adv_out_reg <= RST_ADV;
    else
      adv_out_reg <= adv_next;
  end

  assign adv_ten_half_out     = adv_out_reg[ADV_10H];
  assign adv_ten_full_alt     = adv_out_reg[ADV_10F];
  assign adv_hundred_half_out = adv_out_reg[ADV_100H];
  assign adv_hundred_full_out = adv_out_reg[ADV_100F];

endmodule : ledi_status
